// File: logic/buzzer_pkg.sv
// Constants, register map and types shared by the buzzer melody controller.
package buzzer_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [15:0] ADDR_A_PITCH_LO = 16'ha040;
	localparam logic [15:0] ADDR_A_PITCH_HI = 16'ha041;
	localparam logic [15:0] ADDR_A_LENGTH = 16'ha042;
	localparam logic [15:0] ADDR_A_REST = 16'ha043;
	localparam logic [15:0] ADDR_B_PITCH_LO = 16'ha044;
	localparam logic [15:0] ADDR_B_PITCH_HI = 16'ha045;
	localparam logic [15:0] ADDR_B_LENGTH = 16'ha046;
	localparam logic [15:0] ADDR_B_REST = 16'ha047;
	localparam logic [15:0] ADDR_CONTROL = 16'ha048;
	localparam logic [15:0] ADDR_WINDOW = 16'ha049;
	localparam logic [15:0] ADDR_TIMING = 16'ha04a;
	localparam logic [15:0] ADDR_IRQ_STATUS = 16'ha04b;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'ha04c;

	// ==========================================================
	// Field positions and reset value
	localparam int CTL_EN = 7;
	localparam int CTL_INV = 6;
	localparam int CTL_IENB = 5;
	localparam int CTL_IENA = 4;
	localparam int CTL_FB = 3;
	localparam int CTL_FA = 2;
	localparam int CTL_GOB = 1;
	localparam int CTL_GOA = 0;
	localparam int TU_HI = 7;
	localparam int TU_LO = 6;
	localparam int TU_PRE = 4;
	localparam int TU_WIE = 1;
	localparam int TU_WFLAG = 0;
	localparam int PITCH_HI_W = 4;
	localparam int IRQ_A = 0;
	localparam int IRQ_B = 1;
	localparam int IRQ_W = 2;
	localparam int IRQ_N = 3;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ==========================================================
	// Timing
	localparam int SYS_CLK_HZ = 32'h02fa_f080;
	localparam int SLOW_CLK_HZ = 32'h0000_7d00;
	localparam int MS_PER_S = 32'h0000_03e8;
	localparam int TICKS_PER_MS = SLOW_CLK_HZ / MS_PER_S;
	localparam int UNIT_W = 9;
	localparam int PRESCALE_SHORT = 32'h0000_0020;
	localparam int PRESCALE_LONG = 32'h0000_0040;
	localparam logic [4:0] HALF_SHORT = 5'(PRESCALE_SHORT / 2 - 1);
	localparam logic [4:0] HALF_LONG = 5'(PRESCALE_LONG / 2 - 1);
	localparam int PITCH_W = 12;
	localparam int COUNT_W = 8;

	// ==========================================================
	// Sequencer states
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_TONE, SEQ_REST} seq_t;

endpackage

// File: logic/unit_countdown.sv
// Down counter that counts a loaded value in time-unit ticks.
`timescale 1ns/1ns
module unit_countdown #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic load,
	input wire logic [W-1:0] value,
	input wire logic tick,
	input wire logic abort,
	output logic running,
	output logic done
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic run;
		logic done;
	} cd_state_t;

	cd_state_t s_r;
	cd_state_t s_nxt;

	// A zero count finishes one cycle after the load.
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (load) begin
			s_nxt.cnt = value;
			s_nxt.run = 1'b1;
		end else if (abort) begin
			s_nxt.run = 1'b0;
		end else if (s_r.run) begin
			if (s_r.cnt == '0) begin
				s_nxt.run = 1'b0;
				s_nxt.done = 1'b1;
			end else if (tick) begin
				s_nxt.cnt = s_r.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign running = s_r.run;
	assign done = s_r.done;

endmodule

// File: logic/buzzer_melody_controller.sv
// Two-note buzzer melody controller with register port and window timer.
`timescale 1ns/1ns
// Overview of operation
// RULE_01: Two note slots A and B, each with pitch, length and rest.
// RULE_02: Tone is clock over 32 or 64, over pitch divider plus one.
// RULE_03: Pitch divider is 12 bits, low byte plus high nibble register.
// RULE_04: Prescale select 0 gives clock over 32, 1 gives over 64.
// RULE_05: Length and rest last the time unit times their 8-bit count.
// RULE_06: Time unit codes pick 1, 2, 4 or 8 ms from the slow clock.
// RULE_07: Notes play once in sequence or alternate as a melody.
// RULE_08: Window timer starts whenever note A or B is started.
// RULE_09: Window timer counts its 8-bit setting in the same time unit.
// RULE_10: Window expiry sets its flag; interrupt when enabled; software clears.
// RULE_11: Controller works only while enabled; clearing enable stops it.
// RULE_12: Invert bit set inverts the sounder output.
// RULE_13: Note end sets its flag when enabled; writing zero clears it.
// RULE_14: Writing one starts a note; zero does nothing; clears on completion.
// RULE_15: Both starts in one write play note A then note B.
// RULE_16: Busy bits show the note playing, read where starts are written.
// RULE_17: Note sounds for its length, then silent rest, then completes.
// RULE_18: Output rests at the invert level when disabled or idle.
// RULE_19: All registers reset to zero: disabled, idle, flags clear.
module buzzer_melody_controller (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic slow_clock_32k,
	output logic [7:0] rdata,
	output logic sounder_out,
	output logic amp_power,
	output logic irq
);

	typedef struct packed {
		logic [buzzer_pkg::PITCH_W-1:0] pitch_a;
		logic [buzzer_pkg::PITCH_W-1:0] pitch_b;
		logic [buzzer_pkg::COUNT_W-1:0] len_a;
		logic [buzzer_pkg::COUNT_W-1:0] len_b;
		logic [buzzer_pkg::COUNT_W-1:0] rest_a;
		logic [buzzer_pkg::COUNT_W-1:0] rest_b;
		logic [buzzer_pkg::COUNT_W-1:0] win_cnt;
		logic en;
		logic inv;
		logic iena;
		logic ienb;
		logic fa;
		logic fb;
		logic go_a;
		logic go_b;
		logic [1:0] tu;
		logic pre_sel;
		logic wie;
		logic wflag;
		logic [buzzer_pkg::IRQ_N-1:0] irq_mask;
		logic [buzzer_pkg::IRQ_N-1:0] irq_stat;
		buzzer_pkg::seq_t seq;
		logic cur_b;
		logic s1;
		logic s2;
		logic s3;
		logic slow_lvl;
		logic [buzzer_pkg::UNIT_W-1:0] unit_cnt;
		logic unit_tick;
		logic [4:0] pre_cnt;
		logic [buzzer_pkg::PITCH_W-1:0] div_cnt;
		logic tone;
		logic out;
		logic amp;
		logic irq;
		logic [7:0] rdata;
	} ctl_state_t;

	ctl_state_t s_r;
	ctl_state_t s_nxt;

	logic start_a;
	logic start_b;
	logic note_load;
	logic [buzzer_pkg::COUNT_W-1:0] note_val;
	logic note_abort;
	logic note_done;
	logic win_load;
	logic win_run;
	logic win_done;
	logic next_b;
	logic slow_rise;
	logic pre_hit;
	logic div_hit;
	logic busy_a;
	logic busy_b;
	logic [buzzer_pkg::UNIT_W-1:0] unit_lim;
	logic [buzzer_pkg::PITCH_W-1:0] pitch_cur;

	// ==========================================================
	// Interval counters
	unit_countdown #(.W(buzzer_pkg::COUNT_W)) note_ctr (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.ce(ce),
		.load(note_load),
		.value(note_val),
		.tick(s_r.unit_tick),
		.abort(note_abort),
		.running(),
		.done(note_done)
	);

	unit_countdown #(.W(buzzer_pkg::COUNT_W)) win_ctr (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.ce(ce),
		.load(win_load),
		.value(s_r.win_cnt),
		.tick(s_r.unit_tick),
		.abort(note_abort),
		.running(win_run),
		.done(win_done)
	);

	assign busy_a = (s_r.seq != buzzer_pkg::SEQ_IDLE) && !s_r.cur_b;
	assign busy_b = (s_r.seq != buzzer_pkg::SEQ_IDLE) && s_r.cur_b;

	// ==========================================================
	// Next-state logic
	always_comb begin
		s_nxt = s_r;
		s_nxt.unit_tick = 1'b0;
		s_nxt.rdata = buzzer_pkg::REG_RESET;
		note_load = 1'b0;
		win_load = 1'b0;
		next_b = s_r.cur_b;
		note_val = s_r.len_a;
		slow_rise = 1'b0;
		start_a = wr && addr == buzzer_pkg::ADDR_CONTROL
			&& wdata[buzzer_pkg::CTL_GOA];
		start_b = wr && addr == buzzer_pkg::ADDR_CONTROL
			&& wdata[buzzer_pkg::CTL_GOB];
		pitch_cur = s_r.cur_b ? s_r.pitch_b : s_r.pitch_a;
		if (wr) begin
			case (addr)
				buzzer_pkg::ADDR_A_PITCH_LO: s_nxt.pitch_a[7:0] = wdata; // [RULE_03]
				buzzer_pkg::ADDR_A_PITCH_HI: begin
					s_nxt.pitch_a[11:8] = wdata[buzzer_pkg::PITCH_HI_W-1:0];
				end
				buzzer_pkg::ADDR_A_LENGTH: s_nxt.len_a = wdata;
				buzzer_pkg::ADDR_A_REST: s_nxt.rest_a = wdata;
				buzzer_pkg::ADDR_B_PITCH_LO: s_nxt.pitch_b[7:0] = wdata;
				buzzer_pkg::ADDR_B_PITCH_HI: begin
					s_nxt.pitch_b[11:8] = wdata[buzzer_pkg::PITCH_HI_W-1:0];
				end
				buzzer_pkg::ADDR_B_LENGTH: s_nxt.len_b = wdata;
				buzzer_pkg::ADDR_B_REST: s_nxt.rest_b = wdata;
				buzzer_pkg::ADDR_WINDOW: s_nxt.win_cnt = wdata;
				buzzer_pkg::ADDR_CONTROL: begin
					s_nxt.en = wdata[buzzer_pkg::CTL_EN];
					s_nxt.inv = wdata[buzzer_pkg::CTL_INV];
					s_nxt.ienb = wdata[buzzer_pkg::CTL_IENB];
					s_nxt.iena = wdata[buzzer_pkg::CTL_IENA];
					s_nxt.fb = s_r.fb & wdata[buzzer_pkg::CTL_FB]; // [RULE_13]
					s_nxt.fa = s_r.fa & wdata[buzzer_pkg::CTL_FA]; // [RULE_13]
					s_nxt.go_b = s_r.go_b | start_b; // [RULE_14]
					s_nxt.go_a = s_r.go_a | start_a; // [RULE_14]
				end
				buzzer_pkg::ADDR_TIMING: begin
					s_nxt.tu = wdata[buzzer_pkg::TU_HI:buzzer_pkg::TU_LO];
					s_nxt.pre_sel = wdata[buzzer_pkg::TU_PRE];
					s_nxt.wie = wdata[buzzer_pkg::TU_WIE];
					s_nxt.wflag = s_r.wflag & wdata[buzzer_pkg::TU_WFLAG]; // [RULE_10]
				end
				buzzer_pkg::ADDR_IRQ_STATUS: begin
					s_nxt.irq_stat = s_r.irq_stat & ~wdata[buzzer_pkg::IRQ_N-1:0];
				end
				buzzer_pkg::ADDR_IRQ_MASK: begin
					s_nxt.irq_mask = wdata[buzzer_pkg::IRQ_N-1:0];
				end
				default: ;
			endcase
		end
		if (rd) begin
			case (addr)
				buzzer_pkg::ADDR_A_PITCH_LO: s_nxt.rdata = s_r.pitch_a[7:0];
				buzzer_pkg::ADDR_A_PITCH_HI: s_nxt.rdata = {4'h0, s_r.pitch_a[11:8]};
				buzzer_pkg::ADDR_A_LENGTH: s_nxt.rdata = s_r.len_a;
				buzzer_pkg::ADDR_A_REST: s_nxt.rdata = s_r.rest_a;
				buzzer_pkg::ADDR_B_PITCH_LO: s_nxt.rdata = s_r.pitch_b[7:0];
				buzzer_pkg::ADDR_B_PITCH_HI: s_nxt.rdata = {4'h0, s_r.pitch_b[11:8]};
				buzzer_pkg::ADDR_B_LENGTH: s_nxt.rdata = s_r.len_b;
				buzzer_pkg::ADDR_B_REST: s_nxt.rdata = s_r.rest_b;
				buzzer_pkg::ADDR_WINDOW: s_nxt.rdata = s_r.win_cnt;
				buzzer_pkg::ADDR_CONTROL: begin
					s_nxt.rdata = {s_r.en, s_r.inv, s_r.ienb, s_r.iena,
						s_r.fb, s_r.fa, busy_b, busy_a}; // [RULE_16]
				end
				buzzer_pkg::ADDR_TIMING: begin
					s_nxt.rdata = {s_r.tu, 1'b0, s_r.pre_sel, 2'b00,
						s_r.wie, s_r.wflag};
				end
				buzzer_pkg::ADDR_IRQ_STATUS: s_nxt.rdata = {5'h00, s_r.irq_stat};
				buzzer_pkg::ADDR_IRQ_MASK: s_nxt.rdata = {5'h00, s_r.irq_mask};
				default: ;
			endcase
		end

		// ======================================================
		// Slow clock filter and time unit
		s_nxt.s1 = slow_clock_32k;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		if (s_r.s2 == s_r.s3) begin
			s_nxt.slow_lvl = s_r.s3;
			slow_rise = s_r.s3 && !s_r.slow_lvl;
		end
		unit_lim = (buzzer_pkg::UNIT_W'(buzzer_pkg::TICKS_PER_MS) << s_r.tu)
			- buzzer_pkg::UNIT_W'(1); // [RULE_06]
		if (slow_rise) begin
			if (s_r.unit_cnt == unit_lim) begin
				s_nxt.unit_cnt = '0;
				s_nxt.unit_tick = 1'b1;
			end else begin
				s_nxt.unit_cnt = s_r.unit_cnt + buzzer_pkg::UNIT_W'(1);
			end
		end

		// ======================================================
		// Tone divider
		pre_hit = s_r.pre_cnt == (s_r.pre_sel ? buzzer_pkg::HALF_LONG
			: buzzer_pkg::HALF_SHORT); // [RULE_04]
		div_hit = s_r.div_cnt == pitch_cur;

		// ======================================================
		// Note sequencer
		unique case (s_r.seq)
			buzzer_pkg::SEQ_IDLE: begin
				if (s_r.go_a || s_r.go_b) begin
					next_b = !s_r.go_a; // [RULE_15]
					s_nxt.seq = buzzer_pkg::SEQ_TONE;
					note_load = 1'b1;
					note_val = next_b ? s_r.len_b : s_r.len_a;
					s_nxt.unit_cnt = '0;
				end
			end
			buzzer_pkg::SEQ_TONE: begin
				if (pre_hit) begin
					s_nxt.pre_cnt = '0;
					if (div_hit) begin
						s_nxt.div_cnt = '0;
						s_nxt.tone = !s_r.tone; // [RULE_02]
					end else begin
						s_nxt.div_cnt = s_r.div_cnt + buzzer_pkg::PITCH_W'(1);
					end
				end else begin
					s_nxt.pre_cnt = s_r.pre_cnt + 5'h01;
				end
				if (note_done) begin
					s_nxt.seq = buzzer_pkg::SEQ_REST; // [RULE_17]
					note_load = 1'b1;
					note_val = s_r.cur_b ? s_r.rest_b : s_r.rest_a; // [RULE_05]
				end
			end
			buzzer_pkg::SEQ_REST: begin
				if (note_done) begin
					if (!s_r.cur_b) begin
						s_nxt.go_a = start_a; // [RULE_14]
						if (s_r.iena) begin
							s_nxt.fa = 1'b1; // [RULE_13]
							s_nxt.irq_stat[buzzer_pkg::IRQ_A] = 1'b1;
						end
					end else begin
						s_nxt.go_b = start_b; // [RULE_14]
						if (s_r.ienb) begin
							s_nxt.fb = 1'b1; // [RULE_13]
							s_nxt.irq_stat[buzzer_pkg::IRQ_B] = 1'b1;
						end
					end
					if (s_r.cur_b ? s_nxt.go_a : s_nxt.go_b) begin
						next_b = !s_r.cur_b; // [RULE_07]
						s_nxt.seq = buzzer_pkg::SEQ_TONE;
					end else if (s_r.cur_b ? s_nxt.go_b : s_nxt.go_a) begin
						s_nxt.seq = buzzer_pkg::SEQ_TONE;
					end else begin
						s_nxt.seq = buzzer_pkg::SEQ_IDLE;
					end
					note_load = s_nxt.seq == buzzer_pkg::SEQ_TONE;
					note_val = next_b ? s_r.len_b : s_r.len_a; // [RULE_05]
				end
			end
		endcase
		s_nxt.cur_b = next_b;
		if (s_nxt.seq != buzzer_pkg::SEQ_TONE || s_r.seq != buzzer_pkg::SEQ_TONE) begin
			s_nxt.pre_cnt = '0;
			s_nxt.div_cnt = '0;
			s_nxt.tone = 1'b0;
		end

		// ======================================================
		// Amplifier supply window
		win_load = (start_a || start_b) && s_nxt.en; // [RULE_08] [RULE_09]
		if (win_done) begin
			s_nxt.wflag = 1'b1; // [RULE_10]
			if (s_r.wie) begin
				s_nxt.irq_stat[buzzer_pkg::IRQ_W] = 1'b1; // [RULE_10]
			end
		end

		// ======================================================
		// Disable and outputs
		note_abort = !s_nxt.en;
		if (!s_nxt.en) begin
			s_nxt.seq = buzzer_pkg::SEQ_IDLE; // [RULE_11]
			s_nxt.go_a = 1'b0;
			s_nxt.go_b = 1'b0;
			s_nxt.tone = 1'b0;
			note_load = 1'b0;
		end
		s_nxt.out = ((s_nxt.seq == buzzer_pkg::SEQ_TONE) && s_nxt.tone)
			^ s_nxt.inv; // [RULE_12] [RULE_18]
		s_nxt.amp = win_run && s_nxt.en;
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_r <= '0; // [RULE_19]
		end else if (ce) begin
			s_r <= s_nxt; // [RULE_01]
		end
	end

	assign rdata = s_r.rdata;
	assign sounder_out = s_r.out;
	assign amp_power = s_r.amp;
	assign irq = s_r.irq;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn || !ce);

	sequence note_finish_a;
		s_r.seq == buzzer_pkg::SEQ_REST && note_done && !s_r.cur_b;
	endsequence

	sequence quiet_two;
		(s_r.seq == buzzer_pkg::SEQ_IDLE) [*2];
	endsequence

	a_disable_stops: assert property (!s_r.en |-> s_r.seq == buzzer_pkg::SEQ_IDLE
		&& !s_r.go_a && !s_r.go_b) else $error("running while disabled"); // [RULE_11]
	a_a_plays_first: assert property (s_r.seq == buzzer_pkg::SEQ_IDLE && s_r.en
		&& s_r.go_a && s_r.go_b |=> s_r.seq == buzzer_pkg::SEQ_TONE && !s_r.cur_b)
		else $error("note B played before A"); // [RULE_15]
	a_rest_follows: assert property (s_r.seq == buzzer_pkg::SEQ_TONE && note_done
		&& s_r.en |=> s_r.seq == buzzer_pkg::SEQ_REST && !s_r.tone)
		else $error("no rest after tone"); // [RULE_17]
	a_end_flag_set: assert property (note_finish_a ##0 s_r.iena && s_r.en
		|=> s_r.fa && s_r.irq_stat[buzzer_pkg::IRQ_A])
		else $error("note A end flag missed"); // [RULE_13]
	a_go_self_clear: assert property (note_finish_a ##0 !start_a |=> !s_r.go_a)
		else $error("start bit not cleared"); // [RULE_14]
	a_window_flag: assert property (win_done |=> s_r.wflag)
		else $error("window flag not set"); // [RULE_10]
	a_window_start: assert property (start_a && wdata[buzzer_pkg::CTL_EN]
		|=> win_run ##1 amp_power) else $error("window not started"); // [RULE_08]
	a_idle_level: assert property (quiet_two |-> sounder_out == s_r.inv)
		else $error("output not at rest level"); // [RULE_18]
	a_tone_toggle: assert property (s_r.seq == buzzer_pkg::SEQ_TONE && pre_hit
		&& div_hit && !note_done && s_r.en |=> s_r.tone != $past(s_r.tone))
		else $error("tone did not toggle"); // [RULE_02]
	a_busy_read: assert property (rd && addr == buzzer_pkg::ADDR_CONTROL && busy_a
		|=> rdata[buzzer_pkg::CTL_GOA]) else $error("busy bit wrong"); // [RULE_16]

endmodule

// File: tb/buzzer_element.sv
// Model of the buzzer element and its switched amplifier supply.
`timescale 1ns/1ns
module buzzer_element (
	input wire logic ref_clk,
	input wire logic sounder_out,
	input wire logic amp_power,
	output logic [15:0] half_len = 16'h0000,
	output logic [15:0] power_len = 16'h0000
);
	logic [15:0] run = 16'h0000;
	logic prev_out = 1'b0;
	logic prev_pw = 1'b0;
	// ==========================================================
	// Measures tone half periods and supply on-time in clock cycles.
	always @(posedge ref_clk) begin
		prev_out <= sounder_out;
		prev_pw <= amp_power;
		if (sounder_out !== prev_out) begin
			half_len <= run;
			run <= 16'h0001;
		end else begin
			run <= run + 16'h0001;
		end
		if (amp_power && !prev_pw) begin
			power_len <= 16'h0001;
		end else if (amp_power) begin
			power_len <= power_len + 16'h0001;
		end
	end
endmodule

// File: tb/test_buzzer_melody_controller.sv
// Register-level testbench of the buzzer melody controller.
`timescale 1ns/1ns
module test_buzzer_melody_controller;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic slow_clock_32k = 1'b0;
	logic [7:0] rdata;
	logic sounder_out;
	logic amp_power;
	logic irq;
	logic [15:0] half_len;
	logic [15:0] power_len;
	logic [7:0] v;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	int t0;
	// ==========================================================
	// Clocks: slow clock period is 8 system clocks, one unit 256.
	always #10 ref_clk = ~ref_clk;
	always #80 slow_clock_32k = ~slow_clock_32k;
	always @(posedge ref_clk) cyc <= cyc + 1;
	buzzer_melody_controller dut (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.ce(1'b1),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.slow_clock_32k(slow_clock_32k),
		.rdata(rdata),
		.sounder_out(sounder_out),
		.amp_power(amp_power),
		.irq(irq)
	);
	buzzer_element element (
		.ref_clk(ref_clk),
		.sounder_out(sounder_out),
		.amp_power(amp_power),
		.half_len(half_len),
		.power_len(power_len)
	);
	// ==========================================================
	// Bus tasks and comparison.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_reg(input logic [15:0] a, input logic [7:0] m,
			input logic [7:0] e, input int lim);
		int k;
		k = 0;
		rd_reg(a, v);
		while ((v & m) !== e && k < lim) begin
			rd_reg(a, v);
			k++;
		end
		check(v & m, e);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#1_500_000;
		n_fail++;
		$display("[FAIL] %0t: watchdog expired", $time);
		report_and_stop();
	end
	// ==========================================================
	// Test sequence.
	initial begin
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		for (int a = 16'ha040; a <= 16'ha04d; a++) begin
			rd_reg(16'(a), v);
			check(v, 8'h00);
		end
		check({sounder_out, amp_power, irq}, 3'b000);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			wr_reg(16'(16'ha040 + i), 8'(8'hf0 + i));
			rd_reg(16'(16'ha040 + i), v);
			check(v, (i % 4 == 1) ? 8'(i) : 8'(8'hf0 + i));
		end
		$display("test slot registers done");
		wr_reg(buzzer_pkg::ADDR_A_PITCH_LO, 8'h02);
		wr_reg(buzzer_pkg::ADDR_A_PITCH_HI, 8'h00);
		wr_reg(buzzer_pkg::ADDR_A_LENGTH, 8'h02);
		wr_reg(buzzer_pkg::ADDR_A_REST, 8'h01);
		wr_reg(buzzer_pkg::ADDR_TIMING, 8'h00);
		wr_reg(buzzer_pkg::ADDR_IRQ_MASK, 8'h07);
		wr_reg(buzzer_pkg::ADDR_CONTROL, 8'h91);
		t0 = cyc;
		rd_reg(buzzer_pkg::ADDR_CONTROL, v);
		check(v & 8'h03, 8'h01);
		repeat (300) @(posedge ref_clk);
		check(half_len, 16'h0030);
		repeat (350) @(posedge ref_clk);
		check(sounder_out, 1'b0);
		wait_reg(buzzer_pkg::ADDR_CONTROL, 8'h07, 8'h04, 200);
		check(cyc - t0 >= 32'h0000_0300 && cyc - t0 <= 32'h0000_0340, 1'b1);
		check(irq, 1'b1);
		rd_reg(buzzer_pkg::ADDR_IRQ_STATUS, v);
		check(v, 8'h01);
		wr_reg(buzzer_pkg::ADDR_IRQ_STATUS, 8'h01);
		wr_reg(buzzer_pkg::ADDR_CONTROL, 8'h80);
		repeat (3) @(posedge ref_clk);
		check(irq, 1'b0);
		rd_reg(buzzer_pkg::ADDR_CONTROL, v);
		check(v, 8'h80);
		$display("test single note done");
		wr_reg(buzzer_pkg::ADDR_B_PITCH_LO, 8'h05);
		wr_reg(buzzer_pkg::ADDR_B_PITCH_HI, 8'h00);
		wr_reg(buzzer_pkg::ADDR_B_LENGTH, 8'h01);
		wr_reg(buzzer_pkg::ADDR_B_REST, 8'h00);
		wr_reg(buzzer_pkg::ADDR_A_LENGTH, 8'h01);
		wr_reg(buzzer_pkg::ADDR_A_REST, 8'h00);
		wr_reg(buzzer_pkg::ADDR_TIMING, 8'h50);
		wr_reg(buzzer_pkg::ADDR_CONTROL, 8'hb3);
		rd_reg(buzzer_pkg::ADDR_CONTROL, v);
		check(v & 8'h03, 8'h01);
		repeat (300) @(posedge ref_clk);
		check(half_len, 16'h0060);
		wait_reg(buzzer_pkg::ADDR_CONTROL, 8'h07, 8'h06, 400);
		repeat (450) @(posedge ref_clk);
		check(half_len, 16'h00c0);
		wait_reg(buzzer_pkg::ADDR_CONTROL, 8'h0f, 8'h0c, 400);
		wr_reg(buzzer_pkg::ADDR_IRQ_STATUS, 8'h07);
		$display("test two notes done");
		wr_reg(buzzer_pkg::ADDR_WINDOW, 8'h03);
		wr_reg(buzzer_pkg::ADDR_TIMING, 8'h02);
		wr_reg(buzzer_pkg::ADDR_IRQ_MASK, 8'h04);
		wr_reg(buzzer_pkg::ADDR_CONTROL, 8'h81);
		repeat (4) @(posedge ref_clk);
		check(amp_power, 1'b1);
		wait_reg(buzzer_pkg::ADDR_TIMING, 8'h01, 8'h01, 500);
		check(power_len >= 16'h0200 && power_len <= 16'h0310, 1'b1);
		check({amp_power, irq}, 2'b01);
		wr_reg(buzzer_pkg::ADDR_TIMING, 8'h02);
		wr_reg(buzzer_pkg::ADDR_IRQ_STATUS, 8'h04);
		repeat (3) @(posedge ref_clk);
		check(irq, 1'b0);
		rd_reg(buzzer_pkg::ADDR_TIMING, v);
		check(v, 8'h02);
		$display("test window done");
		wr_reg(buzzer_pkg::ADDR_A_LENGTH, 8'h0a);
		wr_reg(buzzer_pkg::ADDR_CONTROL, 8'hc1);
		repeat (100) @(posedge ref_clk);
		rd_reg(buzzer_pkg::ADDR_CONTROL, v);
		check(v & 8'h01, 8'h01);
		wr_reg(buzzer_pkg::ADDR_CONTROL, 8'h40);
		wr_reg(buzzer_pkg::ADDR_CONTROL, 8'h41);
		repeat (3) @(posedge ref_clk);
		check({sounder_out, amp_power}, 2'b10);
		rd_reg(buzzer_pkg::ADDR_CONTROL, v);
		check(v, 8'h40);
		$display("test disable done");
		report_and_stop();
	end
endmodule
